/* File: pcsi_core.sv */
// Flag register, program counter, return stack and indirect address decode
//
// Contract
// - Flag-updating instructions override written Z, DC, C
// - Timeout and power-down bits never software writable
// - Clear of flag register sets Z, keeps protected
// - Subtraction flags carry meaning not borrow
// - Counter is 15 bits, high part via latch
// - Every reset clears whole program counter
// - Low byte write copies latch to high
// - Direct call: operand low, latch bits 6:3
// - Computed call: working low, latch high
// - Relative branch adds working or signed operand
// - Sixteen-level 15-bit stack outside memory spaces
// - Calls, interrupts push; returns pop; latch untouched
// - Stack error reset off: stack wraps circularly
// - Overflow and underflow flags always set
// - Stack error reset on: reset on error
// - Pointer write selects entry shown in top
// - Push increments then stores; pop reads, decrements
// - Self-referencing indirect read zero, write dropped
// - Pointers 0x0000-0x1FFF map banked addresses
// - Linear window maps 80-byte general blocks
// - Pointer top bit reads flash low byte
// - Page 0x70 reads data EEPROM, extra cycle
// - Timeout and power-down follow watchdog, sleep
`timescale 1ns/1ps
`include "pcsi_map.svh"

module pcsi_core #(
   parameter logic [14:0] INT_VECTOR    = 15'h0004,
   parameter int          LINEAR_BANKS  = 51
) (
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire logic                 device_reset,
   input  wire logic                 stack_error_reset_enable,
   input  wire logic                 pc_advance,
   input  wire logic                 pc_low_wr,
   input  wire logic                 pc_latch_wr,
   input  wire logic [7:0]           wr_data,
   input  wire logic [7:0]           working_reg,
   input  wire logic                 call_op,
   input  wire logic [10:0]          call_operand,
   input  wire logic                 computed_call_op,
   input  wire logic                 branch_relative_op,
   input  wire logic [8:0]           branch_operand,
   input  wire logic                 branch_by_working_reg,
   input  wire logic                 int_vector_op,
   input  wire logic                 return_op,
   input  wire logic                 flags_wr,
   input  wire logic [2:0]           flag_update_mask,
   input  wire logic                 alu_zero,
   input  wire logic                 alu_digit_carry,
   input  wire logic                 alu_carry,
   input  wire logic                 alu_subtract,
   input  wire logic                 watchdog_clear_op,
   input  wire logic                 sleep_op,
   input  wire logic                 watchdog_timeout,
   input  wire logic                 stack_pointer_wr,
   input  wire logic                 stack_top_low_wr,
   input  wire logic                 stack_top_high_wr,
   input  wire logic                 stack_flags_clear,
   input  wire logic [1:0]           pointer_low_wr,
   input  wire logic [1:0]           pointer_high_wr,
   input  wire logic                 ind_sel,
   output logic      [14:0]          pc,
   output logic      [7:0]           pc_low_byte,
   output logic      [6:0]           pc_high_latch,
   output logic      [4:0]           flags,
   output logic      [4:0]           stack_pointer_reg,
   output logic      [7:0]           stack_top_low,
   output logic      [6:0]           stack_top_high,
   output logic                      stack_overflow_flag,
   output logic                      stack_underflow_flag,
   output logic                      stack_error_reset,
   output logic      [15:0]          indirect_pointer_a,
   output logic      [15:0]          indirect_pointer_b,
   output pcsi_pkg::pcsi_region_e    ind_region,
   output logic      [12:0]          ind_bank_addr,
   output logic      [14:0]          ind_flash_addr,
   output logic      [7:0]           ind_ee_addr,
   output logic                      ind_read_zero,
   output logic                      ind_write_block,
   output logic                      ind_extra_cycle
);
   import pcsi_pkg::*;

   pcsi_state_s s_q;
   pcsi_state_s s_d;

   logic [14:0] tos;
   logic [14:0] pc_inc;
   logic [14:0] push_val;
   logic        push;
   logic        pop;
   logic        mem_lo_en;
   logic        mem_hi_en;
   logic [3:0]  mem_wr_addr;
   logic [14:0] mem_wr_data;
   logic [2:0]  alu_flags;

   // ==========================================================
   // Return stack storage
   // stack outside memory
   pcsi_stack_mem #(
      .DEPTH (`PCSI_STACK_DEPTH)
   ) u_stack (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .rd_addr  (s_d.sp[3:0]),
      .wr_addr  (mem_wr_addr),
      .wr_lo_en (mem_lo_en),
      .wr_hi_en (mem_hi_en),
      .wr_data  (mem_wr_data),
      .rd_data  (tos)
   );

   // ==========================================================
   // Flags as the arithmetic unit reports them
   // borrow inverted here
   always_comb begin
      alu_flags[`PCSI_FLAG_Z]  = alu_zero;
      alu_flags[`PCSI_FLAG_DC] = alu_subtract ? ~alu_digit_carry : alu_digit_carry;
      alu_flags[`PCSI_FLAG_C]  = alu_subtract ? ~alu_carry : alu_carry;
   end

   // ==========================================================
   // Next state of counter, flags, stack and pointers
   always_comb begin
      s_d         = s_q;
      s_d.rst_req = 1'b0;
      pc_inc      = s_q.pc + 15'h0001;
      push        = 1'b0;
      pop         = 1'b0;
      push_val    = pc_inc;
      mem_lo_en   = 1'b0;
      mem_hi_en   = 1'b0;
      mem_wr_addr = s_q.sp[3:0];
      mem_wr_data = {wr_data[6:0], wr_data};

      // Flag register write, only the low three bits reach it
      // protected bits kept
      if (flags_wr) begin
         s_d.flags[2:0] = wr_data[2:0];
      end
      for (int k = 0; k < 3; k++) begin
         if (flag_update_mask[k]) begin
            s_d.flags[k] = alu_flags[k];
         end
      end

      // Timeout and power-down tracking
      // watchdog and sleep
      if (watchdog_clear_op) begin
         s_d.flags[`PCSI_FLAG_TO] = 1'b1;
         s_d.flags[`PCSI_FLAG_PD] = 1'b1;
      end
      if (sleep_op) begin
         s_d.flags[`PCSI_FLAG_TO] = 1'b1;
         s_d.flags[`PCSI_FLAG_PD] = 1'b0;
      end
      if (watchdog_timeout) begin
         s_d.flags[`PCSI_FLAG_TO] = 1'b0;
      end

      // Latch write; pushes and pops leave it alone
      // latch untouched
      if (pc_latch_wr) begin
         s_d.pc_high_latch = wr_data[6:0];
      end

      // Program counter loading, one source per cycle
      if (pc_low_wr) begin
         s_d.pc = {s_q.pc_high_latch, wr_data};
      end else if (call_op) begin
         s_d.pc = {s_q.pc_high_latch[6:3], call_operand};
         push   = 1'b1;
      end else if (computed_call_op) begin
         s_d.pc = {s_q.pc_high_latch, working_reg};
         push   = 1'b1;
      end else if (branch_relative_op) begin
         s_d.pc = pc_inc + {{6{branch_operand[8]}}, branch_operand};
      end else if (branch_by_working_reg) begin
         s_d.pc = pc_inc + {7'h00, working_reg};
      end else if (int_vector_op) begin
         s_d.pc   = INT_VECTOR;
         push     = 1'b1;
         push_val = s_q.pc;
      end else if (return_op) begin
         s_d.pc = tos;
         pop    = 1'b1;
      end else if (pc_advance) begin
         s_d.pc = pc_inc;
      end

      // Push: increment first, then store at the new place
      if (push) begin
         if (s_q.sp == `PCSI_SP_FULL) begin
            s_d.ovf = 1'b1;
            if (stack_error_reset_enable) begin
               s_d.rst_req = 1'b1;
            end else begin
               s_d.sp      = 5'h00;
               mem_lo_en   = 1'b1;
               mem_hi_en   = 1'b1;
               mem_wr_addr = 4'h0;
               mem_wr_data = push_val;
            end
         end else begin
            s_d.sp      = s_q.sp + 5'h01;
            mem_lo_en   = 1'b1;
            mem_hi_en   = 1'b1;
            mem_wr_addr = s_d.sp[3:0];
            mem_wr_data = push_val;
         end
      end else if (pop) begin
         if (s_q.sp == `PCSI_SP_EMPTY) begin
            s_d.unf = 1'b1;
            if (stack_error_reset_enable) begin
               s_d.rst_req = 1'b1;
            end else begin
               s_d.sp = `PCSI_SP_WRAP;
            end
         end else begin
            s_d.sp = s_q.sp - 5'h01;
         end
      end else if (stack_pointer_wr) begin
         s_d.sp = wr_data[4:0];
      end else begin
         mem_lo_en = stack_top_low_wr;
         mem_hi_en = stack_top_high_wr;
      end

      // Software clear of stack error flags; a new error wins
      if (stack_flags_clear && !(push && s_q.sp == `PCSI_SP_FULL)) begin
         s_d.ovf = 1'b0;
      end
      if (stack_flags_clear && !(pop && s_q.sp == `PCSI_SP_EMPTY)) begin
         s_d.unf = 1'b0;
      end

      // Pointer byte writes for both indirect pointers
      for (int n = 0; n < 2; n++) begin
         if (pointer_low_wr[n]) begin
            s_d.ptr[n][7:0] = wr_data;
         end
         if (pointer_high_wr[n]) begin
            s_d.ptr[n][15:8] = wr_data;
         end
      end

      // Non power-up reset: counter, stack pointer, latch and pointers
      // counter cleared
      if (device_reset) begin
         s_d.pc            = '0;
         s_d.pc_high_latch = '0;
         s_d.sp            = `PCSI_SP_EMPTY;
         s_d.ptr           = '0;
         s_d.rst_req       = 1'b0;
      end
   end

   // ==========================================================
   // State register; power-up reset sets timeout and power-down
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_q       <= '0;
         s_q.flags <= `PCSI_FLAGS_POR;
         s_q.sp    <= `PCSI_SP_EMPTY;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Indirect address decode of the selected pointer
   logic [15:0] ptr_sel;
   logic [11:0] lin_off;
   logic [11:0] lin_bank;
   logic [11:0] lin_idx;

   always_comb begin
      ptr_sel         = ind_sel ? s_q.ptr[1] : s_q.ptr[0];
      lin_off         = ptr_sel[11:0];
      lin_bank        = lin_off / `PCSI_GPR_BLOCK;
      lin_idx         = lin_off - 12'(lin_bank * `PCSI_GPR_BLOCK);
      ind_region      = PCSI_REG_NONE;
      ind_bank_addr   = '0;
      ind_flash_addr  = ptr_sel[14:0];
      ind_ee_addr     = ptr_sel[7:0];
      ind_read_zero   = 1'b1;
      ind_write_block = 1'b1;
      ind_extra_cycle = 1'b0;
      if (ptr_sel[15]) begin
         ind_region      = PCSI_REG_FLASH;
         ind_read_zero   = 1'b0;
         ind_extra_cycle = 1'b1;
      end else if (ptr_sel[15:8] == `PCSI_EE_PAGE) begin
         ind_region      = PCSI_REG_EEPROM;
         ind_read_zero   = 1'b0;
         ind_extra_cycle = 1'b1;
      end else if (ptr_sel <= `PCSI_BANKED_TOP) begin
         ind_region    = PCSI_REG_BANKED;
         ind_bank_addr = ptr_sel[12:0];
         ind_read_zero   = (ptr_sel[6:0] <= `PCSI_IND_PORT_LAST);
         ind_write_block = (ptr_sel[6:0] <= `PCSI_IND_PORT_LAST);
      end else if (ptr_sel <= `PCSI_LINEAR_TOP) begin
         ind_region    = PCSI_REG_LINEAR;
         ind_bank_addr = {lin_bank[5:0], 7'(lin_idx[6:0] + `PCSI_GPR_START)};
         ind_read_zero   = (lin_bank >= 12'(LINEAR_BANKS));
         ind_write_block = (lin_bank >= 12'(LINEAR_BANKS));
      end
   end

   // ==========================================================
   // Register outputs
   assign pc                   = s_q.pc;
   assign pc_low_byte          = s_q.pc[7:0];
   assign pc_high_latch        = s_q.pc_high_latch;
   assign flags                = s_q.flags;
   assign stack_pointer_reg    = s_q.sp;
   assign stack_top_low        = tos[7:0];
   assign stack_top_high       = tos[14:8];
   assign stack_overflow_flag  = s_q.ovf;
   assign stack_underflow_flag = s_q.unf;
   assign stack_error_reset    = s_q.rst_req;
   assign indirect_pointer_a   = s_q.ptr[0];
   assign indirect_pointer_b   = s_q.ptr[1];

endmodule

/* File: pcsi_core_asserts.sv */
// Concurrent checks on the core ports, bound into every core instance
`timescale 1ns/1ps
module pcsi_core_asserts (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        device_reset,
   input wire logic        stack_error_reset_enable,
   input wire logic        pc_low_wr,
   input wire logic [7:0]  wr_data,
   input wire logic        call_op,
   input wire logic [10:0] call_operand,
   input wire logic        return_op,
   input wire logic        flags_wr,
   input wire logic        watchdog_clear_op,
   input wire logic        sleep_op,
   input wire logic        watchdog_timeout,
   input wire logic [14:0] pc,
   input wire logic [6:0]  pc_high_latch,
   input wire logic [4:0]  flags,
   input wire logic [4:0]  stack_pointer_reg,
   input wire logic        stack_overflow_flag,
   input wire logic        stack_error_reset
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // A call that wins the pc sources, and the protected flag bits
   logic       calls;
   logic [1:0] prot_bits;
   assign calls = call_op && !pc_low_wr && !device_reset;
   assign prot_bits = flags[4:3];

   // ==========================================================
   // Program counter
   property p_low_wr;
      pc_low_wr && !device_reset |=> pc == {$past(pc_high_latch), $past(wr_data)};
   endproperty
   a_low_wr: assert property (p_low_wr) else $error("low byte write mismatch");
   property p_call_pc;
      calls && !(stack_error_reset_enable && stack_pointer_reg == 5'h0f) |=>
         pc[10:0] == $past(call_operand) && pc[14:11] == 4'($past(pc_high_latch) >> 3);
   endproperty
   a_call_pc: assert property (p_call_pc) else $error("call target mismatch");
   property p_dev_rst;
      device_reset |=> pc == 15'h0 && stack_pointer_reg == 5'h1f;
   endproperty
   a_dev_rst: assert property (p_dev_rst) else $error("device reset left state");

   // ==========================================================
   // Flags
   property p_flag_keep;
      flags_wr && !(sleep_op || watchdog_clear_op || watchdog_timeout) |=>
         prot_bits == $past(prot_bits);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("protected flag written");

   // ==========================================================
   // Stack
   property p_ovf_rst;
      calls && stack_error_reset_enable && stack_pointer_reg == 5'h0f |=>
         stack_error_reset && stack_overflow_flag && stack_pointer_reg == 5'h0f;
   endproperty
   a_ovf_rst: assert property (p_ovf_rst) else $error("overflow reset missing");
   property p_ovf_wrap;
      calls && !stack_error_reset_enable && stack_pointer_reg == 5'h0f |=>
         stack_overflow_flag && stack_pointer_reg == 5'h00 && !stack_error_reset;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("circular overflow wrong");
   property p_push;
      calls && stack_pointer_reg != 5'h0f |=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h01;
   endproperty
   a_push: assert property (p_push) else $error("push pointer wrong");
   property p_pop;
      return_op && !call_op && !pc_low_wr && !device_reset && stack_pointer_reg != 5'h1f |=>
         stack_pointer_reg == $past(stack_pointer_reg) - 5'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop pointer wrong");

   // Main scenarios reached
   c_full: cover property (calls && stack_pointer_reg == 5'h0f);
   c_err: cover property (stack_error_reset);
   c_low: cover property (pc_low_wr);
endmodule

bind pcsi_core pcsi_core_asserts u_chk (.*);

/* File: pcsi_exec_unit.sv */
// Behavioural execution unit that issues one instruction per call
`timescale 1ns/1ps
module pcsi_exec_unit (
   input  wire logic   sys_clk,
   output logic        pc_advance,
   output logic        pc_low_wr,
   output logic        pc_latch_wr,
   output logic        call_op,
   output logic        computed_call_op,
   output logic        branch_relative_op,
   output logic        branch_by_working_reg,
   output logic        int_vector_op,
   output logic        return_op,
   output logic        flags_wr,
   output logic        alu_subtract,
   output logic        watchdog_clear_op,
   output logic        sleep_op,
   output logic        watchdog_timeout,
   output logic        stack_pointer_wr,
   output logic        stack_top_low_wr,
   output logic        stack_top_high_wr,
   output logic        stack_flags_clear,
   output logic [2:0]  flag_update_mask,
   output logic [1:0]  pointer_low_wr,
   output logic [1:0]  pointer_high_wr,
   output logic        alu_zero,
   output logic        alu_digit_carry,
   output logic        alu_carry,
   output logic [7:0]  wr_data,
   output logic [7:0]  working_reg,
   output logic [10:0] call_operand,
   output logic [8:0]  branch_operand
);
   logic [24:0] s;
   logic [10:0] d;
   logic [2:0]  f;
   // Strobes, ALU results and operands fan out from three holders
   assign {pc_advance, pc_low_wr, pc_latch_wr, call_op, computed_call_op, branch_relative_op,
           branch_by_working_reg, int_vector_op, return_op, flags_wr, alu_subtract,
           watchdog_clear_op, sleep_op, watchdog_timeout, stack_pointer_wr, stack_top_low_wr,
           stack_top_high_wr, stack_flags_clear, flag_update_mask, pointer_low_wr,
           pointer_high_wr} = s;
   assign {alu_zero, alu_digit_carry, alu_carry} = f;
   assign wr_data = d[7:0];
   assign working_reg = d[7:0];
   assign call_operand = d;
   assign branch_operand = d[8:0];
   // Idle at start
   initial begin
      s = '0;
      d = '0;
      f = '0;
   end
   // software stack access
   // One instruction held for one cycle; operands scramble once released
   task automatic issue(input logic [24:0] m, input logic [10:0] v, input logic [2:0] a);
      @(negedge sys_clk);
      s = m;
      d = v;
      f = a;
      @(negedge sys_clk);
      s = '0;
      d = ~v;
      f = ~a;
   endtask
endmodule

/* File: pcsi_map.svh */
// Offsets, field positions, reset values and counts of the program counter and stack core
`ifndef PCSI_MAP_SVH
`define PCSI_MAP_SVH

// ==========================================================
// Widths and depths
`define PCSI_PC_W          15
`define PCSI_LATCH_W       7
`define PCSI_STACK_DEPTH   16
`define PCSI_SP_W          5

// ==========================================================
// Flag register field positions
`define PCSI_FLAG_C        0
`define PCSI_FLAG_DC       1
`define PCSI_FLAG_Z        2
`define PCSI_FLAG_PD       3
`define PCSI_FLAG_TO       4

// ==========================================================
// Reset values and stack pointer limits
`define PCSI_FLAGS_POR     5'h18
`define PCSI_SP_EMPTY      5'h1f
`define PCSI_SP_FULL       5'h0f
`define PCSI_SP_WRAP       5'h0e

// ==========================================================
// Indirect address space
`define PCSI_BANKED_TOP    16'h1fff
`define PCSI_LINEAR_BASE   16'h2000
`define PCSI_LINEAR_TOP    16'h2fef
`define PCSI_EE_PAGE       8'h70
`define PCSI_GPR_BLOCK     12'h050
`define PCSI_GPR_START     7'h20
`define PCSI_IND_PORT_LAST 7'h01

`endif

/* File: pcsi_pkg.sv */
// Types shared by the program counter, stack and indirect decode core
package pcsi_pkg;

   // Region of the indirect pointer space
   typedef enum logic [2:0] {
      PCSI_REG_BANKED,
      PCSI_REG_LINEAR,
      PCSI_REG_FLASH,
      PCSI_REG_EEPROM,
      PCSI_REG_NONE
   } pcsi_region_e;

   // Whole state of the core
   typedef struct packed {
      logic [14:0]      pc;
      logic [6:0]       pc_high_latch;
      logic [4:0]       flags;
      logic [4:0]       sp;
      logic             ovf;
      logic             unf;
      logic [1:0][15:0] ptr;
      logic             rst_req;
   } pcsi_state_s;

   // Stack memory state
   typedef struct packed {
      logic [15:0][14:0] mem;
      logic [14:0]       rd;
   } pcsi_stk_s;

endpackage

/* File: pcsi_stack_mem.sv */
// Sixteen-entry return stack memory with registered read and write forwarding
`timescale 1ns/1ps
`include "pcsi_map.svh"

module pcsi_stack_mem #(
   parameter int DEPTH = `PCSI_STACK_DEPTH
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  rd_addr,
   input  wire logic [3:0]  wr_addr,
   input  wire logic        wr_lo_en,
   input  wire logic        wr_hi_en,
   input  wire logic [14:0] wr_data,
   output logic      [14:0] rd_data
);
   import pcsi_pkg::*;

   pcsi_stk_s s_q;
   pcsi_stk_s s_d;

   // ==========================================================
   // Write byte lanes, then read the next address with forwarding
   always_comb begin
      s_d = s_q;
      if (wr_lo_en) begin
         s_d.mem[wr_addr][7:0] = wr_data[7:0];
      end
      if (wr_hi_en) begin
         s_d.mem[wr_addr][14:8] = wr_data[14:8];
      end
      s_d.rd = s_d.mem[rd_addr];
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd;

endmodule

/* File: testbench.sv */
// Self-checking bench for the program counter, stack and indirect decode core
`timescale 1ns/1ps
module testbench;
   import pcsi_pkg::*;
   localparam logic [14:0] INT_V = 15'h0123;
   localparam int ADV = 24, LOW = 23, LAT = 22, CALL = 21, CCAL = 20, BREL = 19, BWRK = 18;
   localparam int INTV = 17, RET = 16, FWR = 15, WCLR = 13, SLP = 12, WTO = 11, SPW = 10;
   localparam int TOPL = 9, TOPH = 8, SCLR = 7;
   logic         sys_clk = 1'b0;
   logic         resetn, device_reset, stack_error_reset_enable, ind_sel;
   logic         pc_advance, pc_low_wr, pc_latch_wr, call_op, computed_call_op, return_op;
   logic         branch_relative_op, branch_by_working_reg, int_vector_op, flags_wr;
   logic         alu_zero, alu_digit_carry, alu_carry, alu_subtract, watchdog_clear_op;
   logic         sleep_op, watchdog_timeout, stack_pointer_wr, stack_top_low_wr;
   logic         stack_top_high_wr, stack_flags_clear, stack_overflow_flag;
   logic         stack_underflow_flag, stack_error_reset, ind_read_zero, ind_write_block;
   logic         ind_extra_cycle;
   logic [1:0]   pointer_low_wr, pointer_high_wr;
   logic [2:0]   flag_update_mask;
   logic [4:0]   flags, stack_pointer_reg;
   logic [6:0]   pc_high_latch, stack_top_high;
   logic [7:0]   wr_data, working_reg, pc_low_byte, stack_top_low, ind_ee_addr;
   logic [8:0]   branch_operand;
   logic [10:0]  call_operand;
   logic [12:0]  ind_bank_addr;
   logic [14:0]  pc, ind_flash_addr;
   logic [15:0]  indirect_pointer_a, indirect_pointer_b;
   pcsi_region_e ind_region;
   int           err_count, samples_checked;
   logic [15:0]  p_tab [6] = '{16'h0001, 16'h0a85, 16'h2050, 16'h8123, 16'h7042, 16'h3000};
   logic [2:0]   f_tab [6] = '{3'h6, 3'h0, 3'h0, 3'h3, 3'h3, 3'h6};
   logic [14:0]  a_tab [6] = '{15'h0001, 15'h0a85, 15'h00a0, 15'h0123, 15'h0042, 15'h0};
   pcsi_region_e r_tab [6] = '{PCSI_REG_BANKED, PCSI_REG_BANKED, PCSI_REG_LINEAR,
                               PCSI_REG_FLASH, PCSI_REG_EEPROM, PCSI_REG_NONE};

   pcsi_core #(.INT_VECTOR(INT_V)) dut (.*);
   pcsi_exec_unit xu (.*);

   // Clock of 100 ns
   always #50 sys_clk = ~sys_clk;

   // ==========================================================
   // Tasks
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic op(input int b, input logic [10:0] v);
      xu.issue(25'h1 << b, v, 3'h0);
   endtask
   task automatic ps(input logic [14:0] p, input logic [4:0] sp, input logic [14:0] t);
      chk({pc, stack_pointer_reg, stack_top_high, stack_top_low}, {p, sp, t});
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      err_count = 0;
      samples_checked = 0;
      resetn = 1'b0;
      device_reset = 1'b0;
      stack_error_reset_enable = 1'b0;
      ind_sel = 1'b0;
      repeat (5) @(negedge sys_clk);
      resetn = 1'b1;
      chk({pc, pc_high_latch, stack_pointer_reg, indirect_pointer_a}, 43'h1f << 16);
      chk(flags, 5'h18);
      op(LAT, 11'h0da);
      op(LOW, 11'h034);
      chk({pc, pc_low_byte}, {15'h5a34, 8'h34});
      op(CALL, 11'h123);
      ps(15'h5923, 5'h00, 15'h5a35);
      op(CCAL, 11'h077);
      ps(15'h5a77, 5'h01, 15'h5924);
      op(RET, 11'h000);
      ps(15'h5924, 5'h00, 15'h5a35);
      op(RET, 11'h000);
      chk({pc, stack_pointer_reg, pc_high_latch}, {15'h5a35, 5'h1f, 7'h5a});
      op(BREL, 11'h1f0);
      chk(pc, 15'h5a26);
      op(BWRK, 11'h0ff);
      op(ADV, 11'h000);
      chk(pc, 15'h5b27);
      op(INTV, 11'h000);
      ps(INT_V, 5'h00, 15'h5b27);
      op(RET, 11'h000);
      chk(pc, 15'h5b27);
      $display("program counter tests done");
      op(FWR, 11'h0e7);
      chk(flags, 5'h1f);
      xu.issue((25'h1 << FWR) | 25'h40, 11'h000, 3'h4);
      chk(flags, 5'h1c);
      xu.issue(25'h4030, 11'h000, 3'h1);
      chk(flags, 5'h1e);
      op(SLP, 11'h000);
      chk(flags, 5'h16);
      op(WTO, 11'h000);
      chk(flags, 5'h06);
      op(WCLR, 11'h000);
      chk(flags, 5'h1e);
      $display("flag tests done");
      op(SPW, 11'h003);
      op(TOPL, 11'h0ab);
      op(TOPH, 11'h045);
      chk({stack_top_high, stack_top_low}, 15'h45ab);
      op(RET, 11'h000);
      chk({pc, stack_pointer_reg}, {15'h45ab, 5'h02});
      op(SPW, 11'h01f);
      repeat (16) op(CALL, 11'h100);
      chk({stack_pointer_reg, stack_overflow_flag}, 6'h1e);
      op(CALL, 11'h100);
      ps(15'h5900, 5'h00, 15'h5901);
      chk({stack_overflow_flag, stack_error_reset}, 2'h2);
      op(SCLR, 11'h000);
      op(SPW, 11'h01f);
      op(RET, 11'h000);
      chk({pc, stack_pointer_reg, stack_underflow_flag}, {15'h5901, 5'h0e, 1'b1});
      stack_error_reset_enable = 1'b1;
      op(SCLR, 11'h000);
      op(SPW, 11'h00f);
      op(CALL, 11'h100);
      chk({stack_pointer_reg, stack_overflow_flag, stack_error_reset}, 7'h3f);
      op(SCLR, 11'h000);
      op(SPW, 11'h01f);
      op(RET, 11'h000);
      chk({stack_pointer_reg, stack_underflow_flag, stack_error_reset}, 7'h7f);
      $display("stack tests done");
      op(LOW, 11'h077);
      device_reset = 1'b1;
      @(negedge sys_clk);
      device_reset = 1'b0;
      chk({pc, pc_high_latch, stack_pointer_reg, flags}, {22'h0, 5'h1f, 5'h1e});
      $display("device reset test done");
      for (int i = 0; i < 6; i++) begin
         logic [14:0] got;
         ind_sel = i[0];
         xu.issue(25'h4 << i[0], 11'(p_tab[i][7:0]), 3'h0);
         xu.issue(25'h1 << i[0], 11'(p_tab[i][15:8]), 3'h0);
         chk({ind_region, ind_read_zero, ind_write_block, ind_extra_cycle}, {r_tab[i], f_tab[i]});
         got = (i == 3) ? ind_flash_addr : (i == 4) ? 15'(ind_ee_addr) : 15'(ind_bank_addr);
         if (i != 5)
            chk(got, a_tab[i]);
      end
      chk({indirect_pointer_a, indirect_pointer_b}, {16'h7042, 16'h3000});
      $display("indirect decode tests done");
      give_verdict();
   end
endmodule
